// ---- logic/ldt_defs.svh ----
// Overview of operation
// - Operation mode: counter advances once per second via prescalers 16 then 2048.
// - Calibration mode bypasses the second prescaler; counter advances every 16 oscillator cycles.
// - After-run target (16 bit) and wake-up target (24 bit) are writable and readable.
// - All 24 counter bits at one is the overflow event.
// - After reset the timer sits idle and does not count until configured.
// - After-run counting starts when the host sets the run bit.
// - Wake-up counting starts when the device enters low-power off mode.
// - Function 1: after-run match raises flag and interrupt, then stops the counter.
// - Function 2: after-run match requests low-power off entry, then stops the counter.
// - Function 3: after-run match enters low-power off, restarts count; wake match wakes, stops.
// - Function 4: in low-power off, wake-up match wakes device and stops the counter.
// - Function 5: in low-power off, the timer wakes the device only at overflow, then counter stops.
// - Function 5: wake by another source leaves the counter running.
// - Control register holds function selection and run control.
`ifndef LDT_DEFS_SVH
`define LDT_DEFS_SVH

`define LDT_ADDR_CTRL 8'h00
`define LDT_ADDR_AFTER_RUN 8'h04
`define LDT_ADDR_WAKE_TGT 8'h08
`define LDT_ADDR_COUNT 8'h0c
`define LDT_ADDR_STATUS 8'h10
`define LDT_ADDR_MASK 8'h14
`define LDT_ADDR_STATE 8'h18

`define LDT_CTRL_FUNC_LSB 0
`define LDT_CTRL_FUNC_MSB 2
`define LDT_CTRL_RUN_BIT 3
`define LDT_CTRL_CALIB_BIT 4

`define LDT_ST_AR_MATCH 0
`define LDT_ST_WAKE 1
`define LDT_ST_OVERFLOW 2
`define LDT_ST_LOW_POWER_OFF_MODE_REQ 3
`define LDT_ST_OTHER_WAKE 4
`define LDT_ST_WIDTH 5

`define LDT_CTRL_RST 5'h00
`define LDT_AFTER_RUN_RST 16'h0000
`define LDT_WAKE_TGT_RST 24'h000000
`define LDT_STATUS_RST 5'h00
`define LDT_MASK_RST 5'h01

`define LDT_CLK_HZ 32'h0131_2d00
`define LDT_OSC_HZ 32'h0000_8000
`define LDT_PRE1_DIV 32'h0000_0010
`define LDT_PRE2_DIV 32'h0000_0800
`define LDT_COUNT_MAX 24'hff_ffff

`endif

// ---- logic/ldt_pkg.sv ----
package ldt_pkg;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_AFTER_RUN = 5'b00010,
      ST_WAIT_LOW_POWER_OFF_MODE = 5'b00100,
      ST_WAKE_RUN = 5'b01000,
      ST_STOPPED = 5'b10000
   } ldt_state_t;

   typedef enum logic [2:0] {
      FN_NONE = 3'h0,
      FN_FLAG = 3'h1,
      FN_AR_OFF = 3'h2,
      FN_AR_CYCLE = 3'h3,
      FN_WAKE = 3'h4,
      FN_OVERFLOW = 3'h5
   } ldt_func_t;

   typedef struct packed {
      logic calib;
      logic run;
      logic [2:0] func;
   } ldt_ctrl_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } ldt_bus_req_t;

endpackage

// ---- logic/ldt_prescaler.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ldt_defs.svh"

module ldt_prescaler import ldt_pkg::*; #(
   parameter int CLK_HZ = `LDT_CLK_HZ,
   parameter int OSC_HZ = `LDT_OSC_HZ,
   parameter int PRE1_DIV = `LDT_PRE1_DIV,
   parameter int PRE2_DIV = `LDT_PRE2_DIV
) (
   input wire logic clk_sys_in, // System clock
   input wire logic sys_rst_in, // Synchronous reset, high
   input wire logic clr_in, // Restart divider phase
   input wire logic calib_in, // Bypass second stage
   output logic tick_out // One-cycle count enable
);
   localparam int P1W = $clog2(PRE1_DIV);
   localparam int P2W = $clog2(PRE2_DIV);

   logic [31:0] acc;
   logic [P1W-1:0] pre1;
   logic [P2W-1:0] pre2;

   // Fractional accumulator: oscillator rate on average, jitter of one system cycle
   wire [31:0] acc_sum = acc + 32'(OSC_HZ);
   wire osc_tick = acc_sum >= 32'(CLK_HZ);
   wire [31:0] next_acc = osc_tick ? acc_sum - 32'(CLK_HZ) : acc_sum;
   wire pre1_wrap = osc_tick && (pre1 == P1W'(PRE1_DIV - 1));
   wire pre2_wrap = pre1_wrap && (pre2 == P2W'(PRE2_DIV - 1));
   wire next_tick = calib_in ? pre1_wrap : pre2_wrap;

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in || clr_in) begin
         acc <= 32'h0;
         pre1 <= '0;
         pre2 <= '0;
         tick_out <= 1'b0;
      end else begin
         acc <= next_acc;
         pre1 <= osc_tick ? pre1 + P1W'(1) : pre1;
         pre2 <= pre1_wrap ? pre2 + P2W'(1) : pre2;
         tick_out <= next_tick;
      end
   end

   tick_stage_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (next_tick && !clr_in) |=> tick_out && $past(pre1) == P1W'(PRE1_DIV - 1))
      else $error("tick without first stage wrap");

endmodule
`default_nettype wire

// ---- logic/ldt_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ldt_defs.svh"

module ldt_timer import ldt_pkg::*; #(
   parameter int CLK_HZ = `LDT_CLK_HZ,
   parameter int OSC_HZ = `LDT_OSC_HZ,
   parameter int PRE1_DIV = `LDT_PRE1_DIV,
   parameter int PRE2_DIV = `LDT_PRE2_DIV
) (
   input wire logic clk_sys_in, // System clock, 20 MHz
   input wire logic sys_rst_in, // Synchronous reset, high
   input wire logic [7:0] reg_addr_in, // Register byte address
   input wire logic [31:0] reg_wdata_in, // Write data
   input wire logic reg_wr_in, // Write strobe
   input wire logic reg_rd_in, // Read strobe
   output logic [31:0] reg_rdata_out, // Read data, cycle after strobe
   input wire logic low_power_off_mode_active_in, // Device is in low-power off mode
   input wire logic other_wake_in, // Pulse: woken by another source
   output logic low_power_off_mode_req_out, // Pulse: request low-power off entry
   output logic wake_req_out, // Pulse: wake device into init state
   output logic interrupt_n_out // Interrupt, active low
);
   ldt_bus_req_t req;
   ldt_ctrl_t ctrl;
   ldt_state_t state;
   ldt_state_t next_state;
   logic [15:0] after_run;
   logic [23:0] wake_tgt;
   logic [23:0] count;
   logic [23:0] next_count;
   logic [`LDT_ST_WIDTH-1:0] status;
   logic [`LDT_ST_WIDTH-1:0] mask;
   logic low_power_off_mode_q;
   logic tick;

   assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

   // Address decode
   wire wr_ctrl = req.wr && (req.addr == `LDT_ADDR_CTRL);
   wire wr_ar = req.wr && (req.addr == `LDT_ADDR_AFTER_RUN);
   wire wr_wk = req.wr && (req.addr == `LDT_ADDR_WAKE_TGT);
   wire wr_status = req.wr && (req.addr == `LDT_ADDR_STATUS);
   wire wr_mask = req.wr && (req.addr == `LDT_ADDR_MASK);
   wire wr_run = req.wdata[`LDT_CTRL_RUN_BIT];

   wire fn_flag = ctrl.func == FN_FLAG;
   wire fn_ar_off = ctrl.func == FN_AR_OFF;
   wire fn_cycle = ctrl.func == FN_AR_CYCLE;
   wire fn_wake = ctrl.func == FN_WAKE;
   wire fn_ovf = ctrl.func == FN_OVERFLOW;
   wire fn_after = fn_flag || fn_ar_off || fn_cycle;
   // The start write may carry the function too, so decode the incoming field
   wire [2:0] wr_func = req.wdata[`LDT_CTRL_FUNC_MSB:`LDT_CTRL_FUNC_LSB];
   wire wr_fn_after = (wr_func == FN_FLAG) || (wr_func == FN_AR_OFF) || (wr_func == FN_AR_CYCLE);
   wire idle_like = (state == ST_IDLE) || (state == ST_STOPPED);

   wire go_ar = idle_like && wr_fn_after && wr_ctrl && wr_run && !ctrl.run;
   wire low_power_off_mode_rise = low_power_off_mode_active_in && !low_power_off_mode_q;
   // wake phase begins on low-power off entry
   wire go_wk = low_power_off_mode_rise && ((idle_like && (fn_wake || fn_ovf)) || (state == ST_WAIT_LOW_POWER_OFF_MODE));

   // clearing run pauses the count so it can be read steadily
   wire counting = (state == ST_AFTER_RUN) || (state == ST_WAKE_RUN);
   wire count_en = counting && ctrl.run && tick;
   wire [23:0] count_inc = count + 24'h1;
   wire ar_hit = count_en && (state == ST_AFTER_RUN) && (count_inc == {8'h00, after_run});
   wire wk_hit = count_en && (state == ST_WAKE_RUN) && (fn_cycle || fn_wake) && (count_inc == wake_tgt);
   wire ovf_hit = count_en && (state == ST_WAKE_RUN) && fn_ovf && (count_inc == `LDT_COUNT_MAX);
   wire other_in_wk = (state == ST_WAKE_RUN) && other_wake_in;

   wire [`LDT_ST_WIDTH-1:0] events = {
      other_in_wk && fn_ovf,
      ar_hit && (fn_ar_off || fn_cycle),
      ovf_hit,
      wk_hit || ovf_hit,
      ar_hit && fn_flag
   };
   wire [`LDT_ST_WIDTH-1:0] w1c = wr_status ? req.wdata[`LDT_ST_WIDTH-1:0] : '0;
   // New events win over a write-one clear in the same cycle
   wire [`LDT_ST_WIDTH-1:0] next_status = (status & ~w1c) | events;

   // Hardware sets run on wake phase entry; a host write may change it otherwise
   wire next_run = go_wk ? 1'b1 : (wr_ctrl ? wr_run : ctrl.run);
   wire ldt_ctrl_t next_ctrl = wr_ctrl
      ? '{calib: req.wdata[`LDT_CTRL_CALIB_BIT], run: next_run,
          func: req.wdata[`LDT_CTRL_FUNC_MSB:`LDT_CTRL_FUNC_LSB]}
      : '{calib: ctrl.calib, run: next_run, func: ctrl.func};

   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         ST_IDLE, ST_STOPPED: begin
            if (go_ar) begin
               next_state = ST_AFTER_RUN;
               next_count = 24'h0;
            end else if (go_wk) begin
               next_state = ST_WAKE_RUN;
               next_count = 24'h0;
            end
         end
         ST_AFTER_RUN: begin
            if (ar_hit && fn_cycle) begin
               // clear and wait for low-power entry
               next_state = ST_WAIT_LOW_POWER_OFF_MODE;
               next_count = 24'h0;
            end else if (ar_hit) begin
               next_state = ST_STOPPED;
               next_count = count_inc;
            end else if (count_en) begin
               next_count = count_inc;
            end
         end
         ST_WAIT_LOW_POWER_OFF_MODE: begin
            if (go_wk) begin
               next_state = ST_WAKE_RUN;
            end
         end
         ST_WAKE_RUN: begin
            if (wk_hit || ovf_hit) begin
               next_state = ST_STOPPED;
               next_count = count_inc;
            end else if (count_en) begin
               // other wake sources leave this running
               next_count = count_inc;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_count = 24'h0;
         end
      endcase
   end

   ldt_prescaler #(
      .CLK_HZ(CLK_HZ),
      .OSC_HZ(OSC_HZ),
      .PRE1_DIV(PRE1_DIV),
      .PRE2_DIV(PRE2_DIV)
   ) u_prescaler (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .clr_in(go_ar || go_wk),
      .calib_in(ctrl.calib),
      .tick_out(tick)
   );

   // Read mux; unmapped addresses return zero
   wire [31:0] rd_mux =
      (req.addr == `LDT_ADDR_CTRL) ? {27'h0, ctrl} :
      (req.addr == `LDT_ADDR_AFTER_RUN) ? {16'h0, after_run} :
      (req.addr == `LDT_ADDR_WAKE_TGT) ? {8'h0, wake_tgt} :
      (req.addr == `LDT_ADDR_COUNT) ? {8'h0, count} :
      (req.addr == `LDT_ADDR_STATUS) ? {27'h0, status} :
      (req.addr == `LDT_ADDR_MASK) ? {27'h0, mask} :
      (req.addr == `LDT_ADDR_STATE) ? {27'h0, state} : 32'h0;

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         state <= ST_IDLE;
         count <= 24'h0;
         ctrl <= `LDT_CTRL_RST;
         low_power_off_mode_q <= 1'b0;
      end else begin
         state <= next_state;
         count <= next_count;
         ctrl <= next_ctrl;
         low_power_off_mode_q <= low_power_off_mode_active_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         after_run <= `LDT_AFTER_RUN_RST;
         wake_tgt <= `LDT_WAKE_TGT_RST;
         mask <= `LDT_MASK_RST;
      end else begin
         after_run <= wr_ar ? req.wdata[15:0] : after_run;
         wake_tgt <= wr_wk ? req.wdata[23:0] : wake_tgt;
         mask <= wr_mask ? req.wdata[`LDT_ST_WIDTH-1:0] : mask;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         status <= `LDT_STATUS_RST;
         reg_rdata_out <= 32'h0;
         low_power_off_mode_req_out <= 1'b0;
         wake_req_out <= 1'b0;
         interrupt_n_out <= 1'b1;
      end else begin
         status <= next_status;
         reg_rdata_out <= req.rd ? rd_mux : 32'h0;
         low_power_off_mode_req_out <= ar_hit && (fn_ar_off || fn_cycle);
         // timer wake goes to the power controller as an init wake-up
         wake_req_out <= wk_hit || ovf_hit;
         // interrupt one cycle behind the status bit
         interrupt_n_out <= ~|(status & mask);
      end
   end

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence s_flag_hit;
      (state == ST_AFTER_RUN) && ar_hit && fn_flag;
   endsequence

   sequence s_cycle_hit;
      (state == ST_AFTER_RUN) && ar_hit && fn_cycle;
   endsequence

   sequence s_overflow_hit;
      (state == ST_WAKE_RUN) && fn_ovf && count_en && (count == 24'hff_fffe);
   endsequence

   sequence s_stop_pulse(logic sig);
      sig && (state == ST_STOPPED) ##1 !sig;
   endsequence

   idle_holds_a: assert property (
      ((state == ST_IDLE) && !go_ar && !go_wk) |=> $stable(count))
      else $error("idle counter moved");

   run_start_a: assert property (
      go_ar |=> (state == ST_AFTER_RUN) && (count == 24'h0) && ctrl.run)
      else $error("run bit did not start after-run phase");

   low_power_off_mode_start_a: assert property (
      go_wk |=> (state == ST_WAKE_RUN) && (count == 24'h0) && ctrl.run)
      else $error("low-power entry did not start wake phase");

   flag_stop_a: assert property (
      s_flag_hit |=> status[`LDT_ST_AR_MATCH] && (state == ST_STOPPED) ##1 !interrupt_n_out || !mask[0])
      else $error("function 1 match missed flag or stop");

   low_power_off_mode_req_a: assert property (
      ((state == ST_AFTER_RUN) && ar_hit && fn_ar_off) |=> s_stop_pulse(low_power_off_mode_req_out))
      else $error("function 2 match did not request low-power off");

   cycle_restart_a: assert property (
      s_cycle_hit |=> low_power_off_mode_req_out && (count == 24'h0) && (state == ST_WAIT_LOW_POWER_OFF_MODE))
      else $error("function 3 did not clear and wait");

   wake_match_a: assert property (
      wk_hit |=> s_stop_pulse(wake_req_out) and (count == $past(wake_tgt)))
      else $error("wake target match did not wake and stop");

   overflow_wake_a: assert property (
      s_overflow_hit |=> wake_req_out && (count == `LDT_COUNT_MAX) && status[`LDT_ST_OVERFLOW])
      else $error("overflow did not wake at all ones");

   other_wake_a: assert property (
      (other_in_wk && fn_ovf && !ovf_hit) |=> (state == ST_WAKE_RUN) && status[`LDT_ST_OTHER_WAKE])
      else $error("other wake stopped the counter");

   stopped_hold_a: assert property (
      ((state == ST_STOPPED) && !go_ar && !go_wk) |=> $stable(count))
      else $error("stopped counter moved");

   paused_hold_a: assert property (
      (counting && !ctrl.run) |=> $stable(count))
      else $error("counter moved with run cleared");

   target_read_a: assert property (
      (req.rd && (req.addr == `LDT_ADDR_WAKE_TGT)) |=> (reg_rdata_out == {8'h0, $past(wake_tgt)}))
      else $error("wake target read back wrong");

   int_track_a: assert property (
      1'b1 |=> (interrupt_n_out == ~|$past(status & mask)))
      else $error("interrupt does not follow masked status");

   rdata_idle_a: assert property (
      !req.rd |=> (reg_rdata_out == 32'h0))
      else $error("read data not zero outside read");

   ovf_stop_a: assert property (
      ovf_hit |=> (state == ST_STOPPED))
      else $error("overflow did not stop the counter");

   wait_hold_a: assert property (
      ((state == ST_WAIT_LOW_POWER_OFF_MODE) && !go_wk) |=> (state == ST_WAIT_LOW_POWER_OFF_MODE) && (count == 24'h0))
      else $error("cleared count moved before low-power entry");

endmodule
`default_nettype wire

// ---- dv/ldt_pmc_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module ldt_pmc_model #(
   parameter int ENTRY_DLY = 4
) (
   input wire logic clk_sys_in, // System clock
   input wire logic sys_rst_in, // Synchronous reset, high
   input wire logic low_power_off_mode_req_in, // Timer asks for low-power off
   input wire logic wake_req_in, // Timer wake-up pulse
   input wire logic go_off_in, // Host command: enter low-power off
   input wire logic ext_wake_in, // Bus or pin wake event
   output logic low_power_off_mode_active_out, // Device sits in low-power off
   output logic other_wake_out // Pulse: woken by another source
);
   int dly;
   logic pend;

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         dly <= 0;
         pend <= 1'b0;
         low_power_off_mode_active_out <= 1'b0;
         other_wake_out <= 1'b0;
      end else begin
         other_wake_out <= ext_wake_in & low_power_off_mode_active_out;
         if (low_power_off_mode_req_in | go_off_in) begin
            pend <= 1'b1;
            dly <= ENTRY_DLY;
         end else if (pend && dly == 0) begin
            pend <= 1'b0;
            low_power_off_mode_active_out <= 1'b1;
         end else if (pend) begin
            dly <= dly - 1;
         end
         if (wake_req_in | ext_wake_in) begin
            low_power_off_mode_active_out <= 1'b0;
         end
      end
   end
endmodule

`default_nettype wire

// ---- dv/ldt_timer_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ldt_defs.svh"

module ldt_timer_tb_top;
   // Shortened divider: 4 * 2 * 4 clocks a tick, calibration 4 * 2
   localparam int T = 32;
   localparam int TC = 8;
   localparam logic [7:0] CT = `LDT_ADDR_CTRL;
   localparam logic [7:0] AR = `LDT_ADDR_AFTER_RUN;
   localparam logic [7:0] WK = `LDT_ADDR_WAKE_TGT;
   localparam logic [7:0] CN = `LDT_ADDR_COUNT;
   localparam logic [7:0] SS = `LDT_ADDR_STATUS;
   localparam logic [7:0] MK = `LDT_ADDR_MASK;
   localparam logic [7:0] SE = `LDT_ADDR_STATE;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic go_off = 1'b0;
   logic ext_wake = 1'b0;
   logic [31:0] rdata;
   logic low_power_off_mode_act, other_wake, low_power_off_mode_req, wake_req, int_n;
   int fails = 0;
   int checks = 0;
   int n;
   logic [31:0] a, b;

   initial begin
      forever #25 clk = ~clk;
   end

   ldt_timer #(.CLK_HZ(20000000), .OSC_HZ(5000000), .PRE1_DIV(2), .PRE2_DIV(4)) u_dut (
      .clk_sys_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .low_power_off_mode_active_in(low_power_off_mode_act),
      .other_wake_in(other_wake), .low_power_off_mode_req_out(low_power_off_mode_req), .wake_req_out(wake_req),
      .interrupt_n_out(int_n));

   ldt_pmc_model #(.ENTRY_DLY(4)) u_pmc (
      .clk_sys_in(clk), .sys_rst_in(rst), .low_power_off_mode_req_in(low_power_off_mode_req), .wake_req_in(wake_req),
      .go_off_in(go_off), .ext_wake_in(ext_wake), .low_power_off_mode_active_out(low_power_off_mode_act),
      .other_wake_out(other_wake));

   task automatic tally_and_finish();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_rng(input int got, input int lo, input int hi);
      checks++;
      if (got < lo || got > hi) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] ad, output logic [31:0] d);
      @(posedge clk);
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic chk(input logic [7:0] ad, input logic [31:0] exp);
      logic [31:0] d;
      rd_reg(ad, d);
      cmp_val(d, exp);
   endtask

   // Far-side command: 0 enters low-power off, 1 wakes by another source
   task automatic pulse(input int w);
      @(posedge clk);
      if (w != 0) begin
         ext_wake <= 1'b1;
      end else begin
         go_off <= 1'b1;
      end
      @(posedge clk);
      ext_wake <= 1'b0;
      go_off <= 1'b0;
   endtask

   // Event 0 interrupt low, 1 low-power request, 2 wake request; k counts edges
   task automatic wt(input int sel, output int k);
      k = 0;
      do begin
         @(posedge clk);
         #1 k++;
      end while (!(sel == 0 ? int_n === 1'b0 : sel == 1 ? low_power_off_mode_req === 1'b1 : wake_req === 1'b1) && k < 4000);
      if (k >= 4000) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, k, sel);
         tally_and_finish();
      end
   endtask

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (100) @(posedge clk);
      chk(CN, 32'h0);
      chk(SE, 32'h1);
      chk(CT, 32'h0);
      chk(AR, 32'h0);
      chk(WK, 32'h0);
      chk(SS, 32'h0);
      chk(MK, 32'h1);
      cmp_val(int_n, 1'b1);
      wr_reg(AR, 32'hffff_ffff);
      chk(AR, 32'h0000_ffff);
      wr_reg(WK, 32'hffff_ffff);
      chk(WK, 32'h00ff_ffff);
      wr_reg(8'h1c, 32'h5);
      chk(8'h1c, 32'h0);
      wr_reg(CN, 32'h5);
      chk(CN, 32'h0);
      wr_reg(AR, 32'h3);
      wr_reg(CT, 32'h09);
      wt(0, n);
      cmp_rng(n, 3 * T - 3, 3 * T + 5);
      wr_reg(CT, 32'h01);
      repeat (100) @(posedge clk);
      chk(CN, 32'h3);
      chk(SE, 32'h10);
      chk(SS, 32'h01);
      wr_reg(SS, 32'h01);
      repeat (3) @(posedge clk);
      cmp_val(int_n, 1'b1);
      wr_reg(AR, 32'h5);
      wr_reg(CT, 32'h19);
      wt(0, n);
      cmp_rng(n, 5 * TC - 3, 5 * TC + 5);
      wr_reg(CT, 32'h11);
      chk(CN, 32'h5);
      wr_reg(SS, 32'h1f);
      wr_reg(CT, 32'h02);
      wr_reg(AR, 32'h2);
      wr_reg(CT, 32'h0a);
      wt(1, n);
      cmp_rng(n, 2 * T - 3, 2 * T + 5);
      repeat (10) @(posedge clk);
      chk(SE, 32'h10);
      cmp_val(int_n, 1'b1);
      wr_reg(MK, 32'h08);
      repeat (2) @(posedge clk);
      cmp_val(int_n, 1'b0);
      wr_reg(SS, 32'h08);
      repeat (2) @(posedge clk);
      cmp_val(int_n, 1'b1);
      wr_reg(MK, 32'h01);
      pulse(1);
      wr_reg(CT, 32'h03);
      wr_reg(AR, 32'h2);
      wr_reg(WK, 32'h3);
      wr_reg(CT, 32'h0b);
      wt(1, n);
      cmp_rng(n, 2 * T - 3, 2 * T + 5);
      wt(2, n);
      cmp_rng(n, 3 * T - 3, 3 * T + 12);
      wr_reg(CT, 32'h03);
      chk(CN, 32'h3);
      chk(SS, 32'h0a);
      chk(SE, 32'h10);
      wr_reg(SS, 32'h1f);
      wr_reg(CT, 32'h04);
      wr_reg(WK, 32'h2);
      pulse(0);
      wt(2, n);
      cmp_rng(n, 2 * T - 3, 2 * T + 12);
      chk(SS, 32'h02);
      chk(SE, 32'h10);
      wr_reg(SS, 32'h1f);
      wr_reg(CT, 32'h05);
      pulse(0);
      repeat (150) @(posedge clk);
      pulse(1);
      repeat (5) @(posedge clk);
      chk(SE, 32'h08);
      wr_reg(CT, 32'h05);
      rd_reg(CN, a);
      cmp_rng(a, 3, 6);
      wr_reg(CT, 32'h0d);
      repeat (320) @(posedge clk);
      wr_reg(CT, 32'h05);
      rd_reg(CN, b);
      cmp_rng(b, a + 9, a + 12);
      repeat (100) @(posedge clk);
      chk(CN, b);
      chk(SS, 32'h10);
      tally_and_finish();
   end
endmodule

`default_nettype wire
